/* File: logic/tsc_pkg.sv */
// Constants and types for the host command handler
package tsc_pkg;
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned CONFIRM_MS      = 110;
    localparam int unsigned CONFIRM_CYC     = CONFIRM_MS * 1000 * CLK_MHZ;
    localparam int unsigned NUM_KEYS        = 48;
    localparam logic [5:0]  MAX_KEY         = 6'h2f;
    localparam int unsigned CFG_LEN         = 64;
    localparam logic [7:0]  CMD_NULL        = 8'h00;
    localparam logic [7:0]  CMD_CFG_LOAD    = 8'h01;
    localparam logic [7:0]  CMD_LL_CAL      = 8'h02;
    localparam logic [7:0]  CMD_CAL_ALL     = 8'h03;
    localparam logic [7:0]  CMD_RESET       = 8'h04;
    localparam logic [7:0]  CMD_LAST        = 8'h0f;
    localparam logic [1:0]  CMD_KEY_HI      = 2'h3;
    localparam logic [7:0]  ACK_READY       = 8'hfe;
    localparam logic [7:0]  ACK_CRC_ERR     = 8'h00;
    localparam logic [7:0]  LAST_RST        = 8'h00;
    localparam logic [15:0] CRC_INIT        = 16'hffff;
    localparam logic [15:0] CRC_POLY        = 16'ha001;

    typedef enum logic [2:0] {
        TSC_IDLE,
        TSC_ARMED,
        TSC_LOAD,
        TSC_CRC_LO,
        TSC_CRC_HI,
        TSC_STORE
    } tsc_state_t;
endpackage

/* File: logic/tsc_reply_q.sv */
// Reply byte queue memory, registered read data
`timescale 1ns/1ns
`default_nettype none
module tsc_reply_q #(
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Push side
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    // Pop side
    input  wire logic       pop,
    output logic            not_empty,
    output logic [7:0]      pop_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [7:0]    mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic [7:0]    data_ff;
    logic [AW-1:0] nxt_wr;
    logic [AW-1:0] nxt_rd;
    logic [AW:0]   nxt_cnt;
    logic [7:0]    nxt_data;
    logic          do_push;
    logic          do_pop;

    // A full queue drops new replies; host retries per its own recovery
    always_comb begin
        do_pop   = pop && (cnt_ff != '0);
        do_push  = push && (cnt_ff != (AW+1)'(DEPTH));
        nxt_wr   = do_push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd   = do_pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt  = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        nxt_data = do_pop ? mem_ff[rd_ff] : data_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff   <= '0;
            rd_ff   <= '0;
            cnt_ff  <= '0;
            data_ff <= 8'h00;
        end else begin
            wr_ff   <= nxt_wr;
            rd_ff   <= nxt_rd;
            cnt_ff  <= nxt_cnt;
            data_ff <= nxt_data;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wr_ff] <= push_data;
        end
    end

    assign not_empty = (cnt_ff != '0);
    assign pop_data  = data_ff;
endmodule
`default_nettype wire

/* File: logic/tsc_cmd_handler.sv */
// Host command interpreter for a 48-key touch sensor controller
// Operation
// - Single-key calibration runs only if sent twice consecutively within 110 ms
// - Single-key calibration recalibrates only addressed key 0..47, unlike all-keys
// - Selected key recalibrates in its own slot; other keys keep sensing
// - Single-key calibration replies inverse of command byte before calibrating; the code pulses cal_key_start in the cycle the reply is queued
// - Stuck keys recalibrate automatically via maximum on-duration timeout
// - Host resets device, checks stored CRC, reloads only if check fails
// - In SPI mode each null byte shifts out one queued reply byte
// - Config load needs doubled command in 110 ms, then block plus CRC
// - Ready code before data, ready after store, zero on CRC failure
// - Load aborts on 110 ms byte gap; no reply if doubling incomplete
// - Block stored even with bad CRC, but then marked invalid
// - Sensing restarts after load; host should reset afterwards
// - Doubled low-level calibration acks only when none is in progress
// - Doubled reset acks then resets; no reply if second copy late
// - Last-command query returns inverse of previous byte, even invalid
`timescale 1ns/1ns
`default_nettype none
module tsc_cmd_handler
    import tsc_pkg::*;
#(
    parameter int unsigned CONFIRM_CYCLES = tsc_pkg::CONFIRM_CYC,
    parameter int unsigned BLOCK_LEN      = tsc_pkg::CFG_LEN,
    parameter int unsigned QUEUE_DEPTH    = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Link byte in, from UART or SPI receiver
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       spi_mode,
    // Link byte out
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    // Sensing engine control
    output logic            sense_halt,
    output logic            cal_all_start,
    output logic            cal_key_start,
    output logic [5:0]      cal_key_idx,
    input  wire logic       ll_cal_busy,
    output logic            ll_cal_start,
    output logic            soft_reset,
    // Configuration store
    output logic            cfg_we,
    output logic [7:0]      cfg_wdata,
    output logic            cfg_invalid
);
    import tsc_pkg::*;

    localparam int unsigned TW = $clog2(CONFIRM_CYCLES + 1);
    localparam int unsigned BW = $clog2(BLOCK_LEN + 1);

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic needs_double(input logic [7:0] b);
        logic key_ok;
        key_ok = (b[7:6] == CMD_KEY_HI) && (b[5:0] <= MAX_KEY);
        return key_ok || b == CMD_CFG_LOAD || b == CMD_LL_CAL
            || b == CMD_CAL_ALL || b == CMD_RESET;
    endfunction

    tsc_state_t    state_ff,  nxt_state;
    logic [7:0]    pend_ff,   nxt_pend;
    logic [7:0]    last_ff,   nxt_last;
    logic [TW-1:0] tmr_ff,    nxt_tmr;
    logic [BW-1:0] cnt_ff,    nxt_cnt;
    logic [15:0]   crc_ff,    nxt_crc;
    logic [7:0]    crclo_ff,  nxt_crclo;
    logic          inval_ff,  nxt_inval;
    logic          rst_ff,    nxt_rst;
    logic          rst_arm_ff, nxt_rst_arm;
    logic          push;
    logic [7:0]    push_data;
    logic          pop;
    logic          q_ne;
    logic [7:0]    q_data;
    logic          q_vld_ff,  nxt_q_vld;
    logic          timeout;

    assign timeout = (tmr_ff == TW'(CONFIRM_CYCLES));

    always_comb begin
        nxt_state     = state_ff;
        nxt_pend      = pend_ff;
        nxt_last      = last_ff;
        nxt_tmr       = timeout ? tmr_ff : tmr_ff + 1'b1;
        nxt_cnt       = cnt_ff;
        nxt_crc       = crc_ff;
        nxt_crclo     = crclo_ff;
        nxt_inval     = inval_ff;
        nxt_rst       = 1'b0;
        nxt_rst_arm   = rst_arm_ff;
        push          = 1'b0;
        push_data     = 8'h00;
        cal_all_start = 1'b0;
        cal_key_start = 1'b0;
        ll_cal_start  = 1'b0;
        cfg_we        = 1'b0;
        cfg_wdata     = rx_data;
        // Reset only after the ack has left the queue
        if (rst_arm_ff && !q_ne && !q_vld_ff) begin
            nxt_rst     = 1'b1;
            nxt_rst_arm = 1'b0;
        end
        unique case (state_ff)
            TSC_IDLE, TSC_ARMED: begin
                if (state_ff == TSC_ARMED && timeout) begin
                    nxt_state = TSC_IDLE;
                end
                // In SPI mode null bytes only drain replies and leave the history alone
                if (rx_valid && !(spi_mode && rx_data == CMD_NULL)) begin
                    nxt_tmr  = '0;
                    nxt_last = rx_data;
                    if (rx_data == CMD_LAST) begin
                        push      = 1'b1;
                        push_data = ~last_ff;
                        nxt_state = TSC_IDLE;
                    end else if (state_ff == TSC_ARMED && !timeout
                                 && rx_data == pend_ff) begin
                        nxt_state = TSC_IDLE;
                        push      = 1'b1;
                        push_data = ~rx_data;
                        if (rx_data == CMD_CFG_LOAD) begin
                            push_data = ACK_READY;
                            nxt_state = TSC_LOAD;
                            nxt_cnt   = '0;
                            nxt_crc   = CRC_INIT;
                        end else if (rx_data == CMD_LL_CAL) begin
                            push         = !ll_cal_busy;
                            ll_cal_start = !ll_cal_busy;
                        end else if (rx_data == CMD_CAL_ALL) begin
                            cal_all_start = 1'b1;
                        end else if (rx_data == CMD_RESET) begin
                            nxt_rst_arm = 1'b1;
                        end else begin
                            cal_key_start = 1'b1;
                        end
                    end else if (needs_double(rx_data)) begin
                        nxt_state = TSC_ARMED;
                        nxt_pend  = rx_data;
                    end else begin
                        nxt_state = TSC_IDLE;
                    end
                end
            end
            TSC_LOAD, TSC_CRC_LO, TSC_CRC_HI: begin
                if (timeout) begin
                    nxt_state = TSC_IDLE;
                end else if (rx_valid) begin
                    nxt_tmr = '0;
                    if (state_ff == TSC_LOAD) begin
                        cfg_we  = 1'b1;
                        nxt_crc = crc_step(crc_ff, rx_data);
                        nxt_cnt = cnt_ff + 1'b1;
                        if (cnt_ff == BW'(BLOCK_LEN - 1)) begin
                            nxt_state = TSC_CRC_LO;
                        end
                    end else if (state_ff == TSC_CRC_LO) begin
                        nxt_crclo = rx_data;
                        nxt_state = TSC_CRC_HI;
                    end else begin
                        nxt_state = TSC_STORE;
                        nxt_inval = ({rx_data, crclo_ff} != crc_ff);
                    end
                end
            end
            TSC_STORE: begin
                push      = 1'b1;
                push_data = inval_ff ? ACK_CRC_ERR : ACK_READY;
                nxt_state = TSC_IDLE;
            end
            // Two codes are unused; recover to idle if ever upset
            default: begin
                nxt_state = TSC_IDLE;
            end
        endcase
    end

    // UART drains as soon as possible; SPI only on null bytes
    assign pop = q_ne && (spi_mode ? (rx_valid && rx_data == CMD_NULL
                          && (!q_vld_ff || tx_ready))
                          : (!q_vld_ff || tx_ready));
    assign nxt_q_vld = pop ? 1'b1 : (tx_ready ? 1'b0 : q_vld_ff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= TSC_IDLE;
            pend_ff    <= 8'h00;
            last_ff    <= LAST_RST;
            tmr_ff     <= '0;
            cnt_ff     <= '0;
            crc_ff     <= CRC_INIT;
            crclo_ff   <= 8'h00;
            inval_ff   <= 1'b0;
            rst_ff     <= 1'b0;
            rst_arm_ff <= 1'b0;
            q_vld_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            pend_ff    <= nxt_pend;
            last_ff    <= nxt_last;
            tmr_ff     <= nxt_tmr;
            cnt_ff     <= nxt_cnt;
            crc_ff     <= nxt_crc;
            crclo_ff   <= nxt_crclo;
            inval_ff   <= nxt_inval;
            rst_ff     <= nxt_rst;
            rst_arm_ff <= nxt_rst_arm;
            q_vld_ff   <= nxt_q_vld;
        end
    end

    tsc_reply_q #(
        .DEPTH     (QUEUE_DEPTH)
    ) u_q (
        .clk       (clk),
        .rst_n     (rst_n),
        .push      (push),
        .push_data (push_data),
        .pop       (pop),
        .not_empty (q_ne),
        .pop_data  (q_data)
    );

    assign tx_valid    = q_vld_ff;
    assign tx_data     = q_data;
    assign cal_key_idx = pend_ff[5:0];
    assign sense_halt  = (state_ff == TSC_LOAD) || (state_ff == TSC_CRC_LO)
                         || (state_ff == TSC_CRC_HI);
    assign soft_reset  = rst_ff;
    assign cfg_invalid = inval_ff;
endmodule
`default_nettype wire

/* File: tb/tsc_checker.sv */
// Concurrent checks on the command handler ports
`timescale 1ns/1ns
`default_nettype none
module tsc_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Link bytes
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       spi_mode,
    input wire logic       tx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    // Engine and store
    input wire logic       sense_halt,
    input wire logic       cal_all_start,
    input wire logic       cal_key_start,
    input wire logic [5:0] cal_key_idx,
    input wire logic       ll_cal_busy,
    input wire logic       ll_cal_start,
    input wire logic       soft_reset,
    input wire logic       cfg_we,
    input wire logic [7:0] cfg_wdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Nothing in flight, so the ack is the next byte out
    sequence s_quiet;
        !spi_mode && !tx_valid ##1 !tx_valid;
    endsequence
    sequence s_ack_fc;
        ##1 tx_valid && tx_data == 8'hfc;
    endsequence
    property p_cal_ack;
        cal_all_start ##0 s_quiet |-> s_ack_fc;
    endproperty
    property p_all_cause;
        cal_all_start |-> rx_valid && rx_data == 8'h03;
    endproperty
    property p_key_idx;
        cal_key_start |=> cal_key_idx <= 6'h2f;
    endproperty
    property p_ll_free;
        ll_cal_start |-> !ll_cal_busy;
    endproperty
    property p_load_wr;
        cfg_we |-> sense_halt && rx_valid && cfg_wdata == rx_data;
    endproperty
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    property p_spi_pop;
        spi_mode && $rose(tx_valid) |-> $past(rx_valid) && !$past(rx_data);
    endproperty
    property p_rst_pulse;
        soft_reset |-> !tx_valid ##1 !soft_reset;
    endproperty
    a_cal_ack: assert property (p_cal_ack)
        else $error("all-keys ack missing");
    a_all_cause: assert property (p_all_cause)
        else $error("all-keys start without command");
    a_key_idx: assert property (p_key_idx)
        else $error("key index out of range");
    a_ll_free: assert property (p_ll_free)
        else $error("low-level start while busy");
    a_load_wr: assert property (p_load_wr)
        else $error("config write wrong");
    a_hold: assert property (p_hold)
        else $error("reply byte dropped or changed");
    a_spi_pop: assert property (p_spi_pop)
        else $error("spi reply without null byte");
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset before ack taken");
endmodule
bind tsc_cmd_handler tsc_checker u_chk (.clk(clk), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .spi_mode(spi_mode),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .sense_halt(sense_halt), .cal_all_start(cal_all_start),
    .cal_key_start(cal_key_start), .cal_key_idx(cal_key_idx),
    .ll_cal_busy(ll_cal_busy), .ll_cal_start(ll_cal_start),
    .soft_reset(soft_reset), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata));
`default_nettype wire

/* File: tb/tsc_host_model.sv */
// Host side model: sends command bytes, collects replies
`timescale 1ns/1ns
`default_nettype none
module tsc_host_model (
    // Clock
    input wire logic       clk,
    // Bytes to the device
    output logic           rx_valid,
    output logic     [7:0] rx_data,
    // Replies from the device
    output logic           tx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data
);
    logic [7:0] got[$];
    logic       slow;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h5a;
        tx_ready = 1'b1;
        slow     = 1'b0;
    end
    // Slow host takes a reply only every other cycle
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tx_ready <= !slow || !tx_ready;
    end
    // Idle data line shows the inverse, never a stale byte
    task automatic send(input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the host command handler
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tsc_pkg::*;
    localparam int CONF = 50;
    logic       clk, rst_n, rx_valid, spi_mode, tx_ready, tx_valid, kp;
    logic [7:0] rx_data, tx_data, cfg_wdata;
    logic [5:0] cal_key_idx, key_seen;
    logic       sense_halt, cal_all_start, cal_key_start, ll_cal_busy;
    logic       ll_cal_start, soft_reset, cfg_we, cfg_invalid;
    int         failures = 0, checks = 0, n_all = 0, n_key = 0;
    int         n_ll = 0, n_rst = 0, n_we = 0;
    tsc_cmd_handler #(.CONFIRM_CYCLES(CONF), .BLOCK_LEN(4)) DUT (
        .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .spi_mode(spi_mode), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .sense_halt(sense_halt),
        .cal_all_start(cal_all_start), .cal_key_start(cal_key_start),
        .cal_key_idx(cal_key_idx), .ll_cal_busy(ll_cal_busy),
        .ll_cal_start(ll_cal_start), .soft_reset(soft_reset),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_invalid(cfg_invalid));
    tsc_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Index read one cycle late; it suits only a held index, and cal_key_idx is the pend_ff register
    always @(posedge clk) begin
        kp    <= cal_key_start;
        n_all <= n_all + int'(cal_all_start);
        n_key <= n_key + int'(cal_key_start);
        n_ll  <= n_ll + int'(ll_cal_start);
        n_rst <= n_rst + int'(soft_reset);
        n_we  <= n_we + int'(cfg_we);
        if (kp)
            key_seen <= cal_key_idx;
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic reply(input logic [7:0] exp);
        int i;
        for (i = 0; i < 40 && host.got.size() == 0; i++)
            @(posedge clk);
        if (host.got.size() == 0) begin
            failures++;
            $display("ERROR reply expected %0h seen none", exp);
            end_of_test();
        end else
            chk("reply", exp, host.got.pop_front());
    endtask
    task automatic quiet();
        repeat (12) @(posedge clk);
        chk("no reply", 0, host.got.size());
    endtask
    task automatic gap();
        repeat (CONF + 10) @(posedge clk);
    endtask
    task automatic dbl(input logic [7:0] b);
        host.send(b);
        host.send(b);
    endtask
    function automatic logic [15:0] crc(input logic [7:0] d[4]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (d[i]) begin
            c ^= {8'h00, d[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic t_cal_all();
        dbl(8'h03);
        reply(8'hfc);
        host.send(8'h03);
        host.send(8'h0f);
        reply(8'hfc);
        host.send(8'h03);
        gap();
        chk("cal all", 1, n_all);
        dbl(8'h03);
        reply(8'hfc);
    endtask
    task automatic t_keys();
        host.slow <= 1'b1;
        dbl(8'hc0);
        reply(8'h3f);
        chk("key index", 0, key_seen);
        dbl(8'hef);
        reply(8'h10);
        chk("key index", 6'h2f, key_seen);
        dbl(8'hf0);
        host.send(8'h0f);
        reply(8'h0f);
        chk("key count", 2, n_key);
        host.slow <= 1'b0;
    endtask
    task automatic t_ll();
        ll_cal_busy <= 1'b1;
        dbl(8'h02);
        quiet();
        gap();
        ll_cal_busy <= 1'b0;
        dbl(8'h02);
        reply(8'hfd);
        chk("ll start", 1, n_ll);
    endtask
    task automatic t_reset();
        host.send(8'h04);
        gap();
        host.send(8'h04);
        quiet();
        gap();
        dbl(8'h04);
        reply(8'hfb);
        repeat (8) @(posedge clk);
        chk("soft reset", 1, n_rst);
    endtask
    task automatic t_cfg(input logic bad);
        logic [7:0]  blk[4];
        logic [15:0] c;
        blk = '{8'h11, 8'h22, 8'h80, 8'hff};
        c = crc(blk) ^ {15'h0, bad};
        dbl(8'h01);
        reply(8'hfe);
        chk("halt", 1, sense_halt);
        foreach (blk[i]) host.send(blk[i]);
        host.send(c[7:0]);
        host.send(c[15:8]);
        reply(bad ? 8'h00 : 8'hfe);
        chk("cfg writes", bad ? 8 : 4, n_we);
        chk("cfg invalid", bad, cfg_invalid);
        chk("halt", 0, sense_halt);
    endtask
    task automatic t_gap();
        dbl(8'h01);
        reply(8'hfe);
        host.send(8'h33);
        gap();
        chk("halt", 0, sense_halt);
        quiet();
    endtask
    task automatic t_spi();
        spi_mode <= 1'b1;
        dbl(8'h03);
        quiet();
        host.send(8'h00);
        reply(8'hfc);
        chk("cal all", 3, n_all);
        spi_mode <= 1'b0;
    endtask
    initial begin
        rst_n = 1'b0;
        spi_mode = 1'b0;
        ll_cal_busy = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_cal_all();
        t_keys();
        t_ll();
        t_reset();
        t_cfg(1'b0);
        t_cfg(1'b1);
        t_gap();
        t_spi();
        end_of_test();
    end
endmodule
`default_nettype wire
